// >>> verilog/rx_frame_address_filter.sv
// Receive frame address filter with classic Wishbone register slave
//
// Summary of operation
// - Reject frames whose frame type is reserved, unless reserved-type options allow.
// - Reject frames whose version is not accepted by the acceptance setting.
// - Present destination PAN must equal programmed PAN or broadcast 0xFFFF.
// - Short destination equals own short or 0xFFFF; extended equals own 64-bit address.
// - Beacon source PAN must equal own PAN, unless own PAN is 0xFFFF.
// - Source-only data or command frames pass only as coordinator with PAN match.
// - Never pass acknowledgment frames; reject frames with no address field.
// - No address-match event when destination mode is 0/1 and source mode 0.
// - Filter works in basic and extended modes; pass raises unmasked address-match.
// - Promiscuous in auto-ack mode: every frame not discarded as reserved type ends with frame-end; CRC status kept.
// - In promiscuous mode passing frames requesting ACK are still acknowledged unless disabled.
// - Upload without filtering: uncorrupted reserved frames end, no match, no ACK.
// - Upload with filtering: reserved frames filtered like data, ACK needs frame-end.
// - Upload cleared: reserved-type frames are silently discarded.
// - Version acceptance 00 only 0, 01 up to 1, 10 up to 2, 11 any.
// - Extended mode control: filtering bit 5, upload bit 4, promiscuous bit 1.
// - Ack control: version bits 7:6, pending 5, ack-disable 4, coordinator 3, seed 2:0.
// - Short address, PAN and extended address registers, least significant byte first.
// - Frames above the maximum accepted version fail and are not acknowledged.
// - Frame types 0 to 3 are standard, 4 to 7 reserved.
// - Address mode 0 absent, 1 reserved, 2 PAN plus short, 3 PAN plus extended.
`timescale 1ns/1ps
`default_nettype none

module rx_frame_address_filter (
  input wire logic clk,                                // 40 MHz clock
  input wire logic rst_n,                              // Synchronous reset
  input wire logic wb_cyc_i,                           // Bus cycle
  input wire logic wb_stb_i,                           // Bus strobe
  input wire logic wb_we_i,                            // Write enable
  input wire logic [3:0] wb_sel_i,                     // Byte lanes
  input wire logic [7:0] wb_adr_i,                     // Byte address
  input wire logic [31:0] wb_dat_i,                    // Write data
  output logic [31:0] wb_dat_o,                        // Read data
  output logic wb_ack_o,                               // Bus acknowledge
  input wire logic receive_with_auto_ack_mode,         // Extended receive mode
  input wire rx_filter_pkg::rx_stream_type rx_in,      // Received byte stream
  output rx_filter_pkg::rx_event_type rx_event,        // Frame event pulses
  output logic crc_valid                               // Last frame FCS result
);
  import rx_filter_pkg::*;

  // ---------------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------------
  logic [7:0] extended_mode_control;
  logic [7:0] ack_control_and_seed;
  logic [7:0] event_mask;
  logic [7:0] addr_bytes [ADDR_BYTES];
  logic [5:0] reg_index;
  logic bus_req;
  logic reg_wr;

  assign reg_index = wb_adr_i[7:2];
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign reg_wr = bus_req && wb_we_i && wb_sel_i[0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      extended_mode_control <= EXT_MODE_CTRL_RESET;
    end else if (reg_wr && reg_index == IDX_EXT_MODE_CTRL) begin
      extended_mode_control <= wb_dat_i[7:0] & EXT_MODE_CTRL_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_control_and_seed <= ACK_CTRL_SEED_RESET;
    end else if (reg_wr && reg_index == IDX_ACK_CTRL_SEED) begin
      ack_control_and_seed <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      event_mask <= EVENT_MASK_RESET;
    end else if (reg_wr && reg_index == IDX_EVENT_MASK) begin
      event_mask <= wb_dat_i[7:0] & (8'h01 << EM_ADDR_MATCH_BIT);
    end
  end

  genvar g;
  generate
    for (g = 0; g < ADDR_BYTES; g++) begin : g_addr
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          addr_bytes[g] <= (g < ADDR_HIGH_RESET_BYTES) ? ADDR_RESET_ONES : ADDR_RESET_ZERO;
        end else if (reg_wr && reg_index == IDX_SHORT_LOW + 6'(g)) begin
          addr_bytes[g] <= wb_dat_i[7:0];
        end
      end
    end
  endgenerate

  logic [15:0] own_short;
  logic [15:0] own_pan;
  logic [63:0] own_ext;
  assign own_short = {addr_bytes[1], addr_bytes[0]};
  assign own_pan = {addr_bytes[3], addr_bytes[2]};
  assign own_ext = {addr_bytes[11], addr_bytes[10], addr_bytes[9], addr_bytes[8],
                    addr_bytes[7], addr_bytes[6], addr_bytes[5], addr_bytes[4]};

  // ---------------------------------------------------------------------------
  // Frame state seen by software
  // ---------------------------------------------------------------------------
  parse_state_type state;
  logic verdict_pass;
  logic verdict_done;
  logic last_discard;
  logic [7:0] filter_status;
  assign filter_status = {4'h0, last_discard, (state != ST_IDLE), crc_valid, verdict_pass};

  // Unmapped and reserved locations read as zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      if (reg_index == IDX_EXT_MODE_CTRL) begin
        wb_dat_o <= {24'h000000, extended_mode_control};
      end else if (reg_index == IDX_ACK_CTRL_SEED) begin
        wb_dat_o <= {24'h000000, ack_control_and_seed};
      end else if (reg_index >= IDX_SHORT_LOW && reg_index <= IDX_EXT_BYTE7) begin
        wb_dat_o <= {24'h000000, addr_bytes[4'(reg_index - IDX_SHORT_LOW)]};
      end else if (reg_index == IDX_EVENT_MASK) begin
        wb_dat_o <= {24'h000000, event_mask};
      end else if (reg_index == IDX_FILTER_STATUS) begin
        wb_dat_o <= {24'h000000, filter_status};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------------------
  // Configuration snapshot
  // ---------------------------------------------------------------------------
  // Taken at frame start so a write mid-frame cannot split one verdict
  logic [15:0] snap_short;
  logic [15:0] snap_pan;
  logic [63:0] snap_ext;
  logic [7:0] snap_xm;
  logic [7:0] snap_ac;
  logic snap_mask;
  logic snap_aack;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      snap_short <= 16'h0000;
      snap_pan <= 16'h0000;
      snap_ext <= 64'h0000_0000_0000_0000;
      snap_xm <= EXT_MODE_CTRL_RESET;
      snap_ac <= ACK_CTRL_SEED_RESET;
      snap_mask <= 1'b0;
      snap_aack <= 1'b0;
    end else if (rx_in.start) begin
      snap_short <= own_short;
      snap_pan <= own_pan;
      snap_ext <= own_ext;
      snap_xm <= extended_mode_control;
      snap_ac <= ack_control_and_seed;
      snap_mask <= event_mask[EM_ADDR_MATCH_BIT];
      snap_aack <= receive_with_auto_ack_mode;
    end
  end

  // ---------------------------------------------------------------------------
  // Header fields
  // ---------------------------------------------------------------------------
  logic [15:0] fcf;
  logic fcf_full;
  logic [2:0] byte_cnt;
  logic [15:0] dst_pan;
  logic [63:0] dst_addr;
  logic [15:0] src_pan;

  logic [2:0] ftype;
  logic [1:0] dst_mode;
  logic [1:0] src_mode;
  logic [1:0] fversion;
  logic dst_present;
  logic src_present;
  logic src_pan_present;
  logic [2:0] dst_last;

  assign ftype = fcf[FCF_TYPE_MSB:0];
  assign dst_mode = fcf[FCF_DST_MODE_LSB +: 2];
  assign src_mode = fcf[FCF_SRC_MODE_LSB +: 2];
  assign fversion = fcf[FCF_VER_LSB +: 2];
  assign dst_present = dst_mode >= MODE_SHORT;
  assign src_present = src_mode >= MODE_SHORT;
  assign src_pan_present = src_present && !(fcf[FCF_PAN_COMP_BIT] && dst_present);
  assign dst_last = (dst_mode == MODE_EXTENDED) ? EXT_LAST_BYTE : SHORT_LAST_BYTE;

  parse_state_type after_seq;
  parse_state_type after_dst;
  assign after_seq = dst_present ? ST_DST_PAN : (src_present ? ST_SRC_PAN : ST_EVAL);
  assign after_dst = !src_present ? ST_EVAL : (src_pan_present ? ST_SRC_PAN : ST_SRC_ADDR);

  // verdict taken once addressing fields are in
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      byte_cnt <= 3'h0;
      fcf <= 16'h0000;
      fcf_full <= 1'b0;
      dst_pan <= 16'h0000;
      dst_addr <= 64'h0000_0000_0000_0000;
      src_pan <= 16'h0000;
    end else if (rx_in.start) begin
      state <= ST_FCF_LOW;
      byte_cnt <= 3'h0;
      fcf_full <= 1'b0;
      dst_addr <= 64'h0000_0000_0000_0000;
    end else if (rx_in.last) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_FCF_LOW: begin
          if (rx_in.valid) begin
            fcf[7:0] <= rx_in.data;
            state <= ST_FCF_HIGH;
          end
        end
        ST_FCF_HIGH: begin
          if (rx_in.valid) begin
            fcf[15:8] <= rx_in.data;
            fcf_full <= 1'b1;
            state <= ST_SEQ;
          end
        end
        ST_SEQ: begin
          if (rx_in.valid) begin
            byte_cnt <= 3'h0;
            state <= after_seq;
          end
        end
        ST_DST_PAN: begin
          if (rx_in.valid) begin
            dst_pan[byte_cnt[0]*8 +: 8] <= rx_in.data;
            byte_cnt <= byte_cnt[0] ? 3'h0 : 3'h1;
            if (byte_cnt[0]) begin
              state <= ST_DST_ADDR;
            end
          end
        end
        ST_DST_ADDR: begin
          if (rx_in.valid) begin
            dst_addr[byte_cnt*8 +: 8] <= rx_in.data;
            byte_cnt <= (byte_cnt == dst_last) ? 3'h0 : byte_cnt + 3'h1;
            if (byte_cnt == dst_last) begin
              state <= after_dst;
            end
          end
        end
        ST_SRC_PAN: begin
          if (rx_in.valid) begin
            src_pan[byte_cnt[0]*8 +: 8] <= rx_in.data;
            byte_cnt <= byte_cnt[0] ? 3'h0 : 3'h1;
            if (byte_cnt[0]) begin
              state <= ST_SRC_ADDR;
            end
          end
        end
        // Source address itself is never compared, only skipped
        ST_SRC_ADDR: begin
          if (rx_in.valid) begin
            byte_cnt <= (byte_cnt == ((src_mode == MODE_EXTENDED) ? EXT_LAST_BYTE : SHORT_LAST_BYTE))
                        ? 3'h0 : byte_cnt + 3'h1;
            if (byte_cnt == ((src_mode == MODE_EXTENDED) ? EXT_LAST_BYTE : SHORT_LAST_BYTE)) begin
              state <= ST_EVAL;
            end
          end
        end
        ST_EVAL: begin
          state <= ST_WAIT;
        end
        default: begin
          state <= state;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Filter rules
  // ---------------------------------------------------------------------------
  logic is_reserved;
  logic res_filtered;
  logic res_upload_only;
  logic res_discard;
  logic like_data;
  logic ok_type;
  logic ok_version;
  logic ok_dst_pan;
  logic ok_dst_addr;
  logic ok_beacon;
  logic ok_src_only;
  logic ok_present;
  logic filter_ok;
  logic match_ok;
  logic dst_broadcast;
  logic [15:0] eff_src_pan;

  assign is_reserved = ftype[2];
  assign res_filtered = is_reserved && snap_xm[XM_RES_UPLOAD_BIT] && snap_xm[XM_RES_FILTER_BIT];
  // filter bit without upload still discards
  assign res_discard = is_reserved && !snap_xm[XM_RES_UPLOAD_BIT];
  assign res_upload_only = is_reserved && snap_xm[XM_RES_UPLOAD_BIT] && !snap_xm[XM_RES_FILTER_BIT];
  assign like_data = (ftype == TYPE_DATA) || (ftype == TYPE_COMMAND) || res_filtered;

  assign ok_type = !is_reserved || res_filtered;
  assign ok_version = fversion <= snap_ac[AC_FVN_MSB:AC_FVN_LSB];
  assign ok_dst_pan = !dst_present || dst_pan == snap_pan || dst_pan == BROADCAST_ID;
  assign ok_dst_addr = (dst_mode == MODE_SHORT) ?
                       (dst_addr[15:0] == snap_short || dst_addr[15:0] == BROADCAST_ID) :
                       ((dst_mode == MODE_EXTENDED) ? (dst_addr == snap_ext) : 1'b1);
  // Compressed source PAN is the destination PAN
  assign eff_src_pan = src_pan_present ? src_pan : dst_pan;
  assign ok_beacon = (ftype != TYPE_BEACON) || snap_pan == BROADCAST_ID || eff_src_pan == snap_pan;
  assign ok_src_only = !(like_data && !dst_present && src_present) ||
                       (snap_ac[AC_COORD_BIT] && eff_src_pan == snap_pan);
  // no ACK frames, some address present
  assign ok_present = (ftype != TYPE_ACK) && (dst_present || src_present);

  // same filter in basic and extended mode
  assign filter_ok = fcf_full && ok_type && ok_version && ok_dst_pan && ok_dst_addr &&
                     ok_beacon && ok_src_only && ok_present;
  assign match_ok = filter_ok && !(dst_mode < MODE_SHORT && src_mode == 2'h0);
  assign dst_broadcast = dst_mode == MODE_SHORT && dst_addr[15:0] == BROADCAST_ID;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      verdict_pass <= 1'b0;
      verdict_done <= 1'b0;
    end else if (rx_in.start) begin
      verdict_pass <= 1'b0;
      verdict_done <= 1'b0;
    end else if (state == ST_EVAL && !rx_in.last) begin
      verdict_pass <= filter_ok;
      verdict_done <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Frame end and acknowledgment decision
  // ---------------------------------------------------------------------------
  logic pass_now;
  logic end_now;
  logic ack_now;
  assign pass_now = verdict_done && verdict_pass;

  always_comb begin
    end_now = 1'b0;
    if (fcf_full && res_discard) begin
      end_now = 1'b0;
    end else if (!snap_aack) begin
      end_now = 1'b1;
    end else if (snap_xm[XM_PROMISCUOUS_BIT]) begin
      end_now = 1'b1;
    end else if (fcf_full && res_upload_only) begin
      end_now = rx_in.fcs_ok;
    end else begin
      end_now = pass_now && rx_in.fcs_ok;
    end
  end

  // ACK needs pass, FCS, request, no disable
  assign ack_now = snap_aack && pass_now && rx_in.fcs_ok && like_data && fcf[FCF_ACK_REQ_BIT] &&
                   !snap_ac[AC_ACK_DISABLE_BIT] && !dst_broadcast;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_event <= '0;
    end else begin
      rx_event.address_match <= state == ST_EVAL && !rx_in.last && !rx_in.start &&
                                match_ok && !snap_mask;
      rx_event.frame_end <= rx_in.last && end_now;
      rx_event.ack_request <= rx_in.last && ack_now;
      rx_event.ack_pending <= rx_in.last && ack_now && snap_ac[AC_PENDING_BIT] &&
                              ftype == TYPE_COMMAND;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      crc_valid <= 1'b0;
      last_discard <= 1'b0;
    end else if (rx_in.last) begin
      crc_valid <= rx_in.fcs_ok;
      last_discard <= fcf_full && res_discard;
    end
  end

endmodule : rx_frame_address_filter
`default_nettype wire

// >>> verilog/rx_filter_pkg.sv
// Package: register map, field layout, reset values and types of the receive frame filter
package rx_filter_pkg;

  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [5:0] IDX_EXT_MODE_CTRL = 6'h17;
  localparam logic [5:0] IDX_SHORT_LOW = 6'h20;
  localparam logic [5:0] IDX_SHORT_HIGH = 6'h21;
  localparam logic [5:0] IDX_PAN_LOW = 6'h22;
  localparam logic [5:0] IDX_PAN_HIGH = 6'h23;
  localparam logic [5:0] IDX_EXT_BYTE0 = 6'h24;
  localparam logic [5:0] IDX_EXT_BYTE7 = 6'h2b;
  localparam logic [5:0] IDX_ACK_CTRL_SEED = 6'h2e;
  localparam logic [5:0] IDX_EVENT_MASK = 6'h30;
  localparam logic [5:0] IDX_FILTER_STATUS = 6'h31;
  localparam int ADDR_BYTES = 12;
  localparam int ADDR_HIGH_RESET_BYTES = 4;

  // ---------------------------------------------------------------------------
  // Reset values and write masks
  // ---------------------------------------------------------------------------
  localparam logic [7:0] EXT_MODE_CTRL_RESET = 8'h00;
  localparam logic [7:0] EXT_MODE_CTRL_WMASK = 8'h76;
  localparam logic [7:0] ACK_CTRL_SEED_RESET = 8'h42;
  localparam logic [7:0] EVENT_MASK_RESET = 8'h00;
  localparam logic [7:0] ADDR_RESET_ONES = 8'hff;
  localparam logic [7:0] ADDR_RESET_ZERO = 8'h00;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int XM_RES_FILTER_BIT = 5;
  localparam int XM_RES_UPLOAD_BIT = 4;
  localparam int XM_PROMISCUOUS_BIT = 1;
  localparam int AC_FVN_MSB = 7;
  localparam int AC_FVN_LSB = 6;
  localparam int AC_PENDING_BIT = 5;
  localparam int AC_ACK_DISABLE_BIT = 4;
  localparam int AC_COORD_BIT = 3;
  localparam int EM_ADDR_MATCH_BIT = 0;

  // Frame control field layout
  localparam int FCF_TYPE_MSB = 2;
  localparam int FCF_ACK_REQ_BIT = 5;
  localparam int FCF_PAN_COMP_BIT = 6;
  localparam int FCF_DST_MODE_LSB = 10;
  localparam int FCF_VER_LSB = 12;
  localparam int FCF_SRC_MODE_LSB = 14;

  localparam logic [2:0] TYPE_BEACON = 3'h0;
  localparam logic [2:0] TYPE_DATA = 3'h1;
  localparam logic [2:0] TYPE_ACK = 3'h2;
  localparam logic [2:0] TYPE_COMMAND = 3'h3;
  localparam logic [1:0] MODE_SHORT = 2'h2;
  localparam logic [1:0] MODE_EXTENDED = 2'h3;
  localparam logic [15:0] BROADCAST_ID = 16'hffff;
  localparam logic [2:0] SHORT_LAST_BYTE = 3'h1;
  localparam logic [2:0] EXT_LAST_BYTE = 3'h7;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_FCF_LOW, ST_FCF_HIGH, ST_SEQ, ST_DST_PAN, ST_DST_ADDR,
    ST_SRC_PAN, ST_SRC_ADDR, ST_EVAL, ST_WAIT
  } parse_state_type;

  typedef struct packed {
    logic start;
    logic valid;
    logic [7:0] data;
    logic last;
    logic fcs_ok;
  } rx_stream_type;

  typedef struct packed {
    logic address_match;
    logic frame_end;
    logic ack_request;
    logic ack_pending;
  } rx_event_type;

endpackage : rx_filter_pkg

// >>> dv/rx_frame_address_filter_sva.sv
// Checker: bus handshake and frame event timing of the address filter
`timescale 1ns/1ps
`default_nettype none
module rx_frame_address_filter_sva (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input wire rx_filter_pkg::rx_stream_type rx_in, // Stream
  input wire rx_filter_pkg::rx_event_type rx_event, // Events
  input wire logic crc_valid // CRC status
);
  import rx_filter_pkg::*;
  // --------------------------------
  // Properties
  // --------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  property p_dat; wb_dat_o[31:8] == 24'h0 && (wb_ack_o || wb_dat_o[7:0] == 8'h0); endproperty
  property p_end_last; rx_event.frame_end |-> $past(rx_in.last); endproperty
  property p_ack_end; rx_event.ack_request |-> rx_event.frame_end; endproperty
  property p_pend; rx_event.ack_pending |-> rx_event.ack_request; endproperty
  property p_crc; $past(rx_in.last) |-> crc_valid == $past(rx_in.fcs_ok); endproperty
  property p_match_once; rx_event.address_match |=> !rx_event.address_match [*8]; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("no ack after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_dat: assert property (p_dat) else $error("read data outside ack");
  a_end_last: assert property (p_end_last) else $error("frame end not after last");
  a_ack_end: assert property (p_ack_end) else $error("ack without frame end");
  a_pend: assert property (p_pend) else $error("pending without ack");
  a_crc: assert property (p_crc) else $error("crc status wrong");
  a_match_once: assert property (p_match_once) else $error("repeated match");
  c_end: cover property (rx_event.frame_end);
  c_ack: cover property (rx_event.ack_request);
  c_match: cover property (rx_event.address_match);
endmodule : rx_frame_address_filter_sva
bind rx_frame_address_filter rx_frame_address_filter_sva chk_u (.clk(clk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .rx_in(rx_in), .rx_event(rx_event), .crc_valid(crc_valid));
`default_nettype wire

// >>> dv/rx_frame_source.sv
// Partner model: radio receiver handing header bytes to the filter
`timescale 1ns/1ps
`default_nettype none
module rx_frame_source (
  input wire logic clk, // Clock
  output var rx_filter_pkg::rx_stream_type rx // Byte stream
);
  import rx_filter_pkg::*;
  initial rx = '0;
  // --------------------------------
  // Frame sender
  // --------------------------------
  // Idle data is inverted so stale bytes never look valid
  task send(input logic [7:0] b[$], input logic ok);
    @(posedge clk);
    rx <= '{1'b1, 1'b0, ~rx.data, 1'b0, ~ok};
    foreach (b[i]) begin
      @(posedge clk);
      rx <= '{1'b0, 1'b1, b[i], 1'b0, ~ok};
    end
    // Gap so the verdict lands before the frame closes
    repeat (2) begin
      @(posedge clk);
      rx <= '{1'b0, 1'b0, ~rx.data, 1'b0, ~ok};
    end
    @(posedge clk);
    rx <= '{1'b0, 1'b0, ~rx.data, 1'b1, ok};
    @(posedge clk);
    rx <= '{1'b0, 1'b0, ~rx.data, 1'b0, ~ok};
  endtask : send
endmodule : rx_frame_source
`default_nettype wire

// >>> dv/rx_frame_address_filter_tb.sv
// Testbench: register access and frame filtering scenarios
`timescale 1ns/1ps
`default_nettype none
module rx_frame_address_filter_tb;
  import rx_filter_pkg::*;
  localparam logic [95:0] hdr = 96'h5678_1234_abcd;
  logic clk, rst_n, cyc, stb, we, mode, ack, crc;
  logic [7:0] adr, rq;
  logic [3:0] sel;
  logic [31:0] dw, dr;
  wire rx_stream_type rx;
  rx_event_type ev;
  int bad_count, total_checks, nm, nf, na, np, ticks;
  rx_frame_address_filter dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .receive_with_auto_ack_mode(mode), .rx_in(rx), .rx_event(ev), .crc_valid(crc));
  rx_frame_source src_u (.clk(clk), .rx(rx));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // --------------------------------
  // Event monitor and watchdog
  // --------------------------------
  always @(posedge clk) begin
    if (ev.address_match === 1'b1) nm++;
    if (ev.frame_end === 1'b1) nf++;
    if (ev.ack_request === 1'b1) na++;
    if (ev.ack_pending === 1'b1) np++;
    ticks++;
    if (ticks == 20000) begin
      bad_count++;
      summarize();
    end
  end
  task chk(input logic [7:0] s, input logic [7:0] x);
    total_checks++;
    if (s !== x) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, x);
    end
  endtask : chk
  task summarize;
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  // --------------------------------
  // Bus and frame tasks
  // --------------------------------
  task wb(input logic w, input logic [5:0] i, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {i, 2'b00}; dw <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    rq = dr[7:0];
    cyc <= 1'b0; stb <= 1'b0;
  endtask : wb
  task wr(input logic [5:0] i, input logic [7:0] d);
    wb(1'b1, i, d);
  endtask : wr
  task rd(input logic [5:0] i, input logic [7:0] x);
    wb(1'b0, i, 8'h00);
    chk(rq, x);
  endtask : rd
  // Header is FCF, sequence number, then addressing bytes LSB first
  task fr(input logic [15:0] f, input logic [95:0] a, input int n, input logic ok, input logic [3:0] e);
    logic [7:0] q[$];
    q = {f[7:0], f[15:8], 8'h5a};
    for (int i = 0; i < n; i++) q.push_back(a[8*i+:8]);
    nm = 0; nf = 0; na = 0; np = 0;
    src_u.send(q, ok);
    repeat (3) @(posedge clk);
    chk({4'h0, nm != 0, nf != 0, na != 0, np != 0}, {4'h0, e});
    chk({7'h0, crc}, {7'h0, ok});
  endtask : fr
  initial begin
    rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; dw = 32'h0; mode = 1'b1;
    sel = 4'hf;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(6'h17, 8'h00);
    rd(6'h2e, 8'h42);
    rd(6'h20, 8'hff);
    rd(6'h2b, 8'h00);
    rd(6'h3f, 8'h00);
    wr(6'h17, 8'hff);
    rd(6'h17, 8'h76);
    wr(6'h17, 8'h00);
    // Write without the low byte lane must be ignored
    sel <= 4'he;
    wr(6'h17, 8'h02);
    sel <= 4'hf;
    rd(6'h17, 8'h00);
    wr(6'h20, 8'h34); wr(6'h21, 8'h12); wr(6'h22, 8'hcd); wr(6'h23, 8'hab);
    for (int i = 0; i < 8; i++) wr(6'h24 + 6'(i), 8'(i + 1));
    rd(6'h21, 8'h12);
    fr(16'h9861, hdr, 6, 1'b1, 4'he);
    fr(16'h9861, 96'h5678_1234_abce, 6, 1'b1, 4'h0);
    fr(16'h9861, 96'h5678_1234_ffff, 6, 1'b1, 4'he);
    fr(16'h9861, 96'h5678_1235_abcd, 6, 1'b1, 4'h0);
    fr(16'h9861, 96'h5678_ffff_abcd, 6, 1'b1, 4'hc);
    fr(16'h0c01, 96'h0807060504030201_abcd, 10, 1'b1, 4'hc);
    fr(16'h0c01, 96'h0907060504030201_abcd, 10, 1'b1, 4'h0);
    fr(16'h8802, hdr, 6, 1'b1, 4'h0);
    fr(16'h0001, hdr, 0, 1'b1, 4'h0);
    fr(16'h8001, hdr, 4, 1'b1, 4'h0);
    wr(6'h2e, 8'h4a);
    fr(16'h8001, hdr, 4, 1'b1, 4'hc);
    wr(6'h2e, 8'h62);
    fr(16'h9863, hdr, 6, 1'b1, 4'hf);
    fr(16'h8000, hdr, 4, 1'b1, 4'hc);
    fr(16'h8000, 96'h5678_abce, 4, 1'b1, 4'h0);
    for (int m = 0; m < 4; m++) begin
      wr(6'h2e, 8'(m * 64 + 2));
      for (int v = 0; v < 4; v++) fr(16'h8861 + 16'(v * 4096), hdr, 6, 1'b1, (m == 3 || v <= m) ? 4'he : 4'h0);
    end
    wr(6'h2e, 8'h42);
    for (int t = 4; t < 8; t++) fr(16'h9860 + 16'(t), hdr, 6, 1'b1, 4'h0);
    rd(6'h31, 8'h0a);
    wr(6'h17, 8'h10);
    fr(16'h9864, 96'h5678_1234_abce, 6, 1'b1, 4'h4);
    // filtering bit only set together with upload
    wr(6'h17, 8'h30);
    fr(16'h9864, hdr, 6, 1'b1, 4'he);
    fr(16'h9864, hdr, 6, 1'b0, 4'h8);
    wr(6'h17, 8'h02);
    fr(16'h9861, hdr, 6, 1'b0, 4'hc);
    fr(16'h9861, 96'h5678_1234_abce, 6, 1'b1, 4'h4);
    fr(16'h9861, hdr, 6, 1'b1, 4'he);
    wr(6'h2e, 8'h52);
    fr(16'h9861, hdr, 6, 1'b1, 4'hc);
    wr(6'h2e, 8'h42); wr(6'h17, 8'h00); wr(6'h30, 8'h01);
    rd(6'h30, 8'h01);
    fr(16'h9861, hdr, 6, 1'b1, 4'h6);
    wr(6'h30, 8'h00);
    mode <= 1'b0;
    fr(16'h9861, hdr, 6, 1'b1, 4'hc);
    summarize();
  end
endmodule : rx_frame_address_filter_tb
`default_nettype wire
